// ---- inc/asp_cfg.svh ----
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
// ==========================================
// Timing
`define ASP_CLK_PERIOD_NS 8
`define ASP_UPD_TIME_NS 10000
`define ASP_UPD_CYCLES (`ASP_UPD_TIME_NS / `ASP_CLK_PERIOD_NS)
`define ASP_GUARD_TIME_NS 200
`define ASP_GUARD_CYCLES ((`ASP_GUARD_TIME_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_HALF_CYCLES 4'h8
// ==========================================
// Communications byte fields
`define ASP_COMM_RD_BIT 7
`define ASP_COMM_SEL_HI 6
`define ASP_COMM_SEL_LO 4
// ==========================================
// Register indices
`define ASP_SEL_COMM 3'h0
`define ASP_SEL_DATA 3'h1
`define ASP_SEL_MODE 3'h2
`define ASP_SEL_FILT 3'h3
`define ASP_SEL_DAC 3'h4
`define ASP_SEL_OFFS 3'h5
`define ASP_SEL_GAIN 3'h6
// ==========================================
// Register lengths in bits
`define ASP_LEN_STAT 5'h08
`define ASP_LEN_DATA 5'h18
`define ASP_LEN_MODE 5'h10
`define ASP_LEN_FILT 5'h18
`define ASP_LEN_DAC 5'h08
`define ASP_LEN_CAL 5'h18
// ==========================================
// Mode register fields and reset values
`define ASP_MODE_CODE_HI 15
`define ASP_MODE_CODE_LO 13
`define ASP_MODE_IDLE 3'h0
`define ASP_MODE_CONT 3'h1
`define ASP_MODE_CAL_BIT 15
`define ASP_REG_RST 24'h000000
`endif

// ---- inc/asp_pkg.sv ----
`include "asp_cfg.svh"
`default_nettype none
package asp_pkg;
    // Device link phase
    typedef enum logic [1:0] {
        ASP_DS_CMD = 2'b01,
        ASP_DS_DATA = 2'b10
    } asp_dstate_t;
    // Host sequencer phase
    typedef enum logic [3:0] {
        ASP_HS_IDLE = 4'b0001,
        ASP_HS_SETUP = 4'b0010,
        ASP_HS_LOW = 4'b0100,
        ASP_HS_HIGH = 4'b1000
    } asp_hstate_t;

    // Bit length of a register transfer
    function automatic logic [4:0] asp_len(input logic [2:0] sel);
        logic [4:0] len;
        len = `ASP_LEN_CAL;
        case (sel)
            `ASP_SEL_COMM: len = `ASP_LEN_STAT;
            `ASP_SEL_DATA: len = `ASP_LEN_DATA;
            `ASP_SEL_MODE: len = `ASP_LEN_MODE;
            `ASP_SEL_FILT: len = `ASP_LEN_FILT;
            `ASP_SEL_DAC: len = `ASP_LEN_DAC;
            default: len = `ASP_LEN_CAL;
        endcase
        return len;
    endfunction : asp_len

    // Mask of the low len bits
    function automatic logic [23:0] asp_mask(input logic [4:0] len);
        return 24'hFFFFFF >> (5'h18 - len);
    endfunction : asp_mask
endpackage : asp_pkg
`default_nettype wire

// ---- inc/asp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface asp_if;
    logic sclk; // Serial clock, host made, idles high
    logic cs_b; // Select, active low
    logic din; // Host to device data
    logic dout; // Device to host data
    logic dout_oe_b; // Device drives dout while low
    logic rdy_b; // Ready status, active low
    logic standby_b; // Standby request, active low
    modport dev (input sclk, cs_b, din, standby_b, output dout, dout_oe_b, rdy_b);
    modport host (output sclk, cs_b, din, standby_b, input dout, dout_oe_b, rdy_b);
endinterface : asp_if
`default_nettype wire

// ---- hw/asp_dev.sv ----
// Summary of operation
// - Standby low stops analog and digital activity
// - Registers keep their values through standby
// - Select low enables transfers; shared bus
// - Select tied low gives three-wire mode
// - Host may use select as frame sync
// - Ready low when new conversion word waits
// - Ready high after complete word read
// - Unread result: ready high just before update
// - Host avoids data reads while ready high
// - Ready high during calibration, low after
// - Output shifts selected register contents out
// - Input shift register writes selected register
// - Several internal events force ready high
`timescale 1ns/1ps
`default_nettype none
`include "asp_cfg.svh"
module asp_dev import asp_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_b_i,
    asp_if.dev link,
    input wire logic [23:0] conv_data_i,
    input wire logic cal_done_i,
    output logic [15:0] mode_o,
    output logic [23:0] filter_o,
    output logic [7:0] dac_o,
    output logic [23:0] offs_o,
    output logic [23:0] gain_o,
    output logic cal_start_o,
    output logic power_down_o
);
    // ==========================================
    // Pin synchronisers
    logic [3:0] sync_a; // First stage: sclk, cs_b, din, standby_b
    logic [3:0] sync_b; // Second stage
    logic sclk_d; // Delayed synced clock for edges
    // Two flops on every pin
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            sync_a <= 4'hD;
            sync_b <= 4'hD;
            sclk_d <= 1'b1;
        end else begin
            sync_a <= {link.sclk, link.cs_b, link.din, link.standby_b};
            sync_b <= sync_a;
            sclk_d <= sync_b[3];
        end
    end
    wire sclk_s = sync_b[3];
    wire cs_b_s = sync_b[2];
    wire din_s = sync_b[1];
    wire stby_b_s = sync_b[0];
    wire sclk_rise = sclk_s & ~sclk_d;
    wire awake = stby_b_s;
    wire selected = ~cs_b_s & awake;
    wire bit_take = selected & sclk_rise;

    // ==========================================
    // Link state
    asp_dstate_t state; // Command or data phase
    logic [7:0] comm; // Communications register
    logic [4:0] bit_cnt; // Bits taken in this phase
    logic [23:0] in_sh; // Input shift register
    logic [23:0] out_sh; // Output shift register
    logic dout_oe_b; // Registered enable
    logic rdy_b; // Ready status
    logic cal_busy; // Calibration running
    logic [10:0] upd_cnt; // Cycles to next output update
    logic [23:0] regs [1:6]; // Register bank by index

    wire [23:0] next_word = {in_sh[22:0], din_s};
    wire comm_rd = next_word[`ASP_COMM_RD_BIT];
    wire [2:0] comm_selw = next_word[`ASP_COMM_SEL_HI:`ASP_COMM_SEL_LO];
    wire rd = comm[`ASP_COMM_RD_BIT];
    wire [2:0] sel = comm[`ASP_COMM_SEL_HI:`ASP_COMM_SEL_LO];
    wire [4:0] len = asp_len(sel);
    wire [4:0] new_len = asp_len(comm_selw);
    wire cmd_last = bit_take & (state == ASP_DS_CMD) & (bit_cnt == 5'h07);
    // data phase only after a comm byte
    wire goes_data = cmd_last & (comm_rd | (comm_selw != `ASP_SEL_COMM));
    wire data_last = bit_take & (state == ASP_DS_DATA) & (bit_cnt == len - 5'h01);
    wire wr_done = data_last & ~rd;
    wire rd_done = data_last & rd & (sel == `ASP_SEL_DATA);

    // ==========================================
    // Conversion and calibration events
    wire [2:0] mode_code = regs[`ASP_SEL_MODE][`ASP_MODE_CODE_HI:`ASP_MODE_CODE_LO];
    wire conv_mode = awake & (mode_code == `ASP_MODE_CONT) & ~cal_busy;
    wire upd_now = conv_mode & (upd_cnt == 11'h000);
    wire guard = conv_mode & (upd_cnt <= 11'(`ASP_GUARD_CYCLES)) & ~upd_now;
    wire mode_wr = wr_done & (sel == `ASP_SEL_MODE);
    wire cal_start = mode_wr & next_word[`ASP_MODE_CAL_BIT];
    wire cal_fin = cal_busy & cal_done_i;

    // Read value, status packed in the low byte
    wire [23:0] stat_word = {16'h0000, rdy_b, cal_busy, ~awake, 2'h0, mode_code};
    wire [23:0] rd_val = (comm_selw == `ASP_SEL_COMM) ? stat_word :
                         (comm_selw == 3'h7) ? 24'h000000 : regs[comm_selw];
    wire [23:0] rd_aligned = rd_val << (5'h18 - new_len);

    // ==========================================
    // Link shifting and phase control
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state <= ASP_DS_CMD;
            bit_cnt <= 5'h00;
            in_sh <= 24'h000000;
            out_sh <= 24'h000000;
            comm <= 8'h00;
            dout_oe_b <= 1'b1;
        end else if (!selected) begin
            // Deselect ends the frame and re-arms the comm phase
            state <= ASP_DS_CMD;
            bit_cnt <= 5'h00;
            dout_oe_b <= 1'b1;
        end else begin
            dout_oe_b <= 1'b0;
            if (bit_take) begin
                in_sh <= next_word;
                bit_cnt <= bit_cnt + 5'h01;
                out_sh <= {out_sh[22:0], 1'b0};
                if (cmd_last) begin
                    comm <= next_word[7:0];
                    bit_cnt <= 5'h00;
                    out_sh <= comm_rd ? rd_aligned : 24'h000000;
                    if (goes_data) begin
                        state <= ASP_DS_DATA;
                    end
                end else if (data_last) begin
                    // count ends frame, select may stay low
                    state <= ASP_DS_CMD;
                    bit_cnt <= 5'h00;
                end
            end
        end
    end

    // ==========================================
    // Register bank, one entry per index
    genvar gi;
    generate
        for (gi = 1; gi <= 6; gi++) begin : g_reg
            wire wr_hit = wr_done & (sel == 3'(gi)) & (gi != `ASP_SEL_DATA);
            wire upd_hit = upd_now & (gi == `ASP_SEL_DATA);
            wire fin_hit = cal_fin & (gi == `ASP_SEL_MODE);
            always_ff @(posedge clock_i) begin
                if (!rst_b_i) begin
                    regs[gi] <= `ASP_REG_RST;
                end else if (wr_hit) begin
                    regs[gi] <= next_word & asp_mask(len);
                end else if (upd_hit) begin
                    regs[gi] <= conv_data_i;
                end else if (fin_hit) begin
                    // Calibration over: mode falls back to idle
                    regs[gi][`ASP_MODE_CODE_HI:`ASP_MODE_CODE_LO] <= `ASP_MODE_IDLE;
                end
            end
        end
    endgenerate

    // ==========================================
    // Update timer, reloaded whenever not converting, standby included
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            upd_cnt <= 11'(`ASP_UPD_CYCLES - 1);
        end else if (!conv_mode) begin
            upd_cnt <= 11'(`ASP_UPD_CYCLES - 1);
        end else if (upd_now) begin
            upd_cnt <= 11'(`ASP_UPD_CYCLES - 1);
        end else begin
            upd_cnt <= upd_cnt - 11'h001;
        end
    end

    // ==========================================
    // Calibration tracking and ready status
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            cal_busy <= 1'b0;
            cal_start_o <= 1'b0;
            rdy_b <= 1'b1;
            power_down_o <= 1'b0;
        end else begin
            power_down_o <= ~awake;
            cal_start_o <= cal_start;
            if (cal_start) begin
                cal_busy <= 1'b1;
            end else if (cal_fin) begin
                cal_busy <= 1'b0;
            end
            if (cal_start) begin
                rdy_b <= 1'b1;
            end else if (cal_fin) begin
                rdy_b <= 1'b0;
            end else if (upd_now) begin
                rdy_b <= 1'b0;
            end else if (guard) begin
                rdy_b <= 1'b1;
            end else if (rd_done) begin
                rdy_b <= 1'b1;
            end else if (mode_wr | ~awake) begin
                rdy_b <= 1'b1;
            end
        end
    end

    // ==========================================
    // Outputs straight from flops
    assign link.dout = out_sh[23];
    assign link.dout_oe_b = dout_oe_b;
    assign link.rdy_b = rdy_b;
    assign mode_o = regs[`ASP_SEL_MODE][15:0];
    assign filter_o = regs[`ASP_SEL_FILT];
    assign dac_o = regs[`ASP_SEL_DAC][7:0];
    assign offs_o = regs[`ASP_SEL_OFFS];
    assign gain_o = regs[`ASP_SEL_GAIN];
endmodule : asp_dev
`default_nettype wire

// ---- hw/asp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "asp_cfg.svh"
module asp_host import asp_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_b_i,
    asp_if.host link,
    input wire logic cmd_valid_i,
    input wire logic cmd_read_i,
    input wire logic [2:0] cmd_sel_i,
    input wire logic [23:0] cmd_wdata_i,
    input wire logic three_wire_i,
    input wire logic standby_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [23:0] rsp_data_o,
    output logic data_ready_o
);
    // ==========================================
    // Pin synchronisers for dout and rdy_b
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            sync_a <= 2'h1;
            sync_b <= 2'h1;
        end else begin
            sync_a <= {link.dout, link.rdy_b};
            sync_b <= sync_a;
        end
    end
    wire dout_s = sync_b[1];
    wire rdy_b_s = sync_b[0];

    // ==========================================
    // Sequencer state
    asp_hstate_t state;
    logic [3:0] tmr; // Half period timer
    logic [5:0] bit_cnt; // Bits sent in frame
    logic [5:0] nbits; // Frame length
    logic [31:0] tx; // Comm byte then data, MSB first
    logic [23:0] rx; // Captured read bits
    logic [4:0] len; // Data length of frame
    logic rd; // Frame is a read
    logic sclk;
    logic cs_b;
    logic din;
    wire [4:0] cmd_len = asp_len(cmd_sel_i);
    // comm-only frame for a comm write
    wire comm_only = ~cmd_read_i & (cmd_sel_i == `ASP_SEL_COMM);
    // hold data reads while ready is high
    wire blocked = cmd_read_i & (cmd_sel_i == `ASP_SEL_DATA) & rdy_b_s;
    wire start = (state == ASP_HS_IDLE) & cmd_valid_i & ~blocked;
    wire half_up = (tmr == `ASP_HALF_CYCLES - 4'h1);
    wire [7:0] comm_byte = {cmd_read_i, cmd_sel_i, 4'h0};
    wire [23:0] wr_aligned = cmd_wdata_i << (5'h18 - cmd_len);

    // ==========================================
    // Frame sequencer
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state <= ASP_HS_IDLE;
            tmr <= 4'h0;
            bit_cnt <= 6'h00;
            nbits <= 6'h08;
            tx <= 32'h00000000;
            rx <= 24'h000000;
            len <= 5'h08;
            rd <= 1'b0;
            sclk <= 1'b1;
            cs_b <= 1'b1;
            din <= 1'b1;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 24'h000000;
        end else begin
            rsp_valid_o <= 1'b0;
            tmr <= half_up ? 4'h0 : tmr + 4'h1;
            unique case (state)
                ASP_HS_IDLE: begin
                    // select stays low in three-wire mode
                    cs_b <= ~three_wire_i;
                    sclk <= 1'b1;
                    tmr <= 4'h0;
                    if (start) begin
                        cs_b <= 1'b0;
                        tx <= {comm_byte, wr_aligned};
                        nbits <= comm_only ? 6'h08 : 6'(cmd_len) + 6'h08;
                        len <= cmd_len;
                        rd <= cmd_read_i;
                        bit_cnt <= 6'h00;
                        state <= ASP_HS_SETUP;
                    end
                end
                ASP_HS_SETUP: begin
                    if (half_up) begin
                        sclk <= 1'b0;
                        din <= tx[31];
                        state <= ASP_HS_LOW;
                    end
                end
                ASP_HS_LOW: begin
                    if (half_up) begin
                        // Sample just before the rising edge
                        rx <= {rx[22:0], dout_s};
                        sclk <= 1'b1;
                        tx <= {tx[30:0], 1'b0};
                        bit_cnt <= bit_cnt + 6'h01;
                        state <= ASP_HS_HIGH;
                    end
                end
                ASP_HS_HIGH: begin
                    if (half_up) begin
                        if (bit_cnt == nbits) begin
                            cs_b <= ~three_wire_i;
                            rsp_valid_o <= rd;
                            rsp_data_o <= rx & asp_mask(len);
                            state <= ASP_HS_IDLE;
                        end else begin
                            sclk <= 1'b0;
                            din <= tx[31];
                            state <= ASP_HS_LOW;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Status and standby outputs
    logic stby_b;
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            stby_b <= 1'b1;
            cmd_ready_o <= 1'b0;
            data_ready_o <= 1'b0;
        end else begin
            stby_b <= ~standby_i;
            cmd_ready_o <= (state == ASP_HS_IDLE) & ~start;
            data_ready_o <= ~rdy_b_s;
        end
    end
    assign link.sclk = sclk;
    assign link.cs_b = cs_b;
    assign link.din = din;
    assign link.standby_b = stby_b;
endmodule : asp_host
`default_nettype wire

// ---- sim/asp_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module asp_properties (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_b,
    input wire logic rdy_b,
    input wire logic standby_b
);
    // ====
    // Single clock domain
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    // ====
    // Serial clock phases
    sequence s_low;
        !sclk [*8] ##1 sclk;
    endsequence
    sequence s_high;
        sclk [*8];
    endsequence
    property p_idle; cs_b |-> sclk; endproperty
    property p_setup; $fell(cs_b) |-> s_high; endproperty
    property p_low; $fell(sclk) |-> s_low; endproperty
    property p_high; $rose(sclk) |-> s_high; endproperty
    // Data lines settle while clock is low
    property p_din; !sclk && $past(!sclk) |-> $stable(din); endproperty
    property p_dout; !sclk && !cs_b |-> $stable(dout); endproperty
    // Output enable follows select
    property p_oe_off; cs_b [*4] |-> dout_oe_b; endproperty
    property p_oe_on; (!cs_b && standby_b) [*5] |-> !dout_oe_b; endproperty
    // Standby forces ready high
    property p_stby; $fell(standby_b) |-> ##[1:6] rdy_b; endproperty
    a_idle: assert property (p_idle) else $error("clock moved while idle");
    a_setup: assert property (p_setup) else $error("short setup");
    a_low: assert property (p_low) else $error("bad low phase");
    a_high: assert property (p_high) else $error("bad high phase");
    a_din: assert property (p_din) else $error("din moved");
    a_dout: assert property (p_dout) else $error("dout moved");
    a_oe_off: assert property (p_oe_off) else $error("dout driven");
    a_oe_on: assert property (p_oe_on) else $error("dout released");
    a_stby: assert property (p_stby) else $error("ready low in standby");
endmodule : asp_properties
`default_nettype wire

// ---- sim/adc_serial_port_ready_status_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port_ready_status_tb_top import asp_pkg::*;;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [23:0] conv_data_i = 24'h0;
    logic cal_done_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic cmd_read_i = 1'b0;
    logic [2:0] cmd_sel_i = 3'h0;
    logic [23:0] cmd_wdata_i = 24'h0;
    logic three_wire_i = 1'b0;
    logic standby_i = 1'b0;
    logic [15:0] mode_o;
    logic [23:0] filter_o, offs_o, gain_o, rsp_data_o;
    logic [7:0] dac_o;
    logic cal_start_o, power_down_o, cmd_ready_o, rsp_valid_o, data_ready_o;
    logic [23:0] mdl [0:7]; // Register model
    logic [23:0] got; // Last read value
    logic cs_hi = 1'b0; // Select seen high
    logic watch_cs = 1'b0; // Select watch armed
    int n_cal = 0; // Calibration start pulses seen
    int lens [0:7] = '{8, 24, 16, 24, 8, 24, 24, 24};
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    asp_if lnk ();
    asp_dev i_asp_dev (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(lnk), .conv_data_i(conv_data_i),
        .cal_done_i(cal_done_i), .mode_o(mode_o), .filter_o(filter_o), .dac_o(dac_o), .offs_o(offs_o),
        .gain_o(gain_o), .cal_start_o(cal_start_o), .power_down_o(power_down_o));
    asp_host i_asp_host (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(lnk), .cmd_valid_i(cmd_valid_i),
        .cmd_read_i(cmd_read_i), .cmd_sel_i(cmd_sel_i), .cmd_wdata_i(cmd_wdata_i),
        .three_wire_i(three_wire_i), .standby_i(standby_i), .cmd_ready_o(cmd_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .data_ready_o(data_ready_o));
    asp_properties i_asp_properties (.clock_i(clock_i), .rst_b_i(rst_b_i), .sclk(lnk.sclk),
        .cs_b(lnk.cs_b), .din(lnk.din), .dout(lnk.dout), .dout_oe_b(lnk.dout_oe_b),
        .rdy_b(lnk.rdy_b), .standby_b(lnk.standby_b));
    // ====
    // Clock, timeout, select monitor
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    always @(negedge clock_i) begin
        cyc++;
        if (watch_cs && lnk.cs_b !== 1'b0) cs_hi = 1'b1;
        if (cal_start_o === 1'b1) n_cal++;
        if (cyc == 60000) begin
            n_mismatch++;
            close_out();
        end
    end
    // ====
    // Shared tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    // One frame; the model takes writes of reachable registers
    task automatic xfer(input logic rd, input logic [2:0] sel, input logic [23:0] wd);
        logic seen_rsp;
        seen_rsp = 1'b0;
        @(negedge clock_i);
        cmd_valid_i = 1'b1;
        cmd_read_i = rd;
        cmd_sel_i = sel;
        cmd_wdata_i = wd;
        while (cmd_ready_o !== 1'b0) @(negedge clock_i);
        cmd_valid_i = 1'b0;
        while (cmd_ready_o !== 1'b1) begin
            @(negedge clock_i);
            if (rsp_valid_o === 1'b1) seen_rsp = 1'b1;
        end
        repeat (2) @(negedge clock_i);
        got = rsp_data_o;
        chk(24'(seen_rsp), 24'(rd));
        if (!rd && sel != 3'h1 && sel != 3'h7) mdl[sel] = wd & (24'hFFFFFF >> (24 - lens[sel]));
    endtask : xfer
    // Optional writes, then read back every register except data
    task automatic regs(input logic wr);
        logic [23:0] st;
        for (int s = 2; s < 7; s++) begin
            if (wr) xfer(1'b0, 3'(s), 24'($urandom()) & (s == 2 ? 24'h1FFF : 24'hFFFFFF));
        end
        for (int s = 2; s < 7; s++) begin
            xfer(1'b1, 3'(s), 24'h0);
            chk(got, mdl[s]);
        end
        chk(mode_o, mdl[2][15:0]);
        chk(filter_o, mdl[3]);
        chk(dac_o, mdl[4][7:0]);
        chk(offs_o, mdl[5]);
        chk(gain_o, mdl[6]);
        st = {16'h0, 1'b1, 4'h0, mdl[2][15:13]};
        xfer(1'b1, 3'h0, 24'h0);
        chk(got, st);
        xfer(1'b1, 3'h7, 24'h0);
        chk(got, 24'h0);
    endtask : regs
    // ====
    // Main sequence
    initial begin
        void'($urandom(86));
        for (int i = 0; i < 8; i++) mdl[i] = 24'h0;
        repeat (20) @(negedge clock_i);
        rst_b_i = 1'b1;
        regs(1'b1);
        // Conversion word and ready handshake
        conv_data_i = 24'($urandom());
        xfer(1'b0, 3'h2, 24'h2000);
        while (data_ready_o !== 1'b1) @(negedge clock_i);
        xfer(1'b1, 3'h1, 24'h0);
        chk(got, conv_data_i);
        chk(lnk.rdy_b, 1'b1);
        // Unread result: ready high just before the update
        conv_data_i = 24'($urandom());
        while (lnk.rdy_b !== 1'b0) @(negedge clock_i);
        while (lnk.rdy_b !== 1'b1) @(negedge clock_i);
        n = 0;
        while (lnk.rdy_b !== 1'b0) begin
            @(negedge clock_i);
            n++;
        end
        chk(24'(n), 24'h000019);
        xfer(1'b1, 3'h1, 24'h0);
        chk(got, conv_data_i);
        // Data read held off while ready is high, then takes the next word
        conv_data_i = 24'($urandom());
        xfer(1'b1, 3'h1, 24'h0);
        chk(got, conv_data_i);
        // Calibration
        xfer(1'b0, 3'h2, 24'h8000);
        chk(lnk.rdy_b, 1'b1);
        chk(24'(n_cal), 24'h000001);
        cal_done_i = 1'b1;
        @(negedge clock_i);
        cal_done_i = 1'b0;
        mdl[2] = 24'h0;
        repeat (6) @(negedge clock_i);
        chk(lnk.rdy_b, 1'b0);
        // Standby keeps registers
        standby_i = 1'b1;
        repeat (20) @(negedge clock_i);
        chk(power_down_o, 1'b1);
        chk(lnk.rdy_b, 1'b1);
        standby_i = 1'b0;
        repeat (20) @(negedge clock_i);
        chk(power_down_o, 1'b0);
        regs(1'b0);
        // Three-wire operation
        three_wire_i = 1'b1;
        repeat (3) @(negedge clock_i);
        watch_cs = 1'b1;
        regs(1'b1);
        chk(cs_hi, 1'b0);
        close_out();
    end
endmodule : adc_serial_port_ready_status_tb_top
`default_nettype wire
